//--- core/alarm_timer.sv
// Cumulative alarm assertion timer with saturation and clear on read
`timescale 1ns/1ns
module alarm_timer
  import thermal_alarm_pkg::*;
#(
  parameter int STEP_CYCLES = TIMER_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic alarm_active_i,
  input wire logic clear_i,
  // Result
  output logic [7:0] timer_value_o
);

  // ----------------------------------------------------------------
  // Prescaler and step counter
  // ----------------------------------------------------------------
  logic [31:0] presc;
  logic [7:0] steps;
  logic seen;
  wire step_tick = alarm_active_i && (presc == 32'(STEP_CYCLES - 1));
  wire steps_full = (steps == TIMER_FULL);

  // Prescaler only runs while asserted so time adds up across assertions
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || clear_i)
      presc <= '0;
    else if (step_tick)
      presc <= '0;
    else if (alarm_active_i)
      presc <= presc + 32'h1;
  end

  // Steps stop at full scale; a read clears, but an ongoing assertion re-marks bit 0
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      steps <= RST_ZERO;
      seen <= 1'b0;
    end
    else if (clear_i)
    begin
      steps <= RST_ZERO;
      seen <= alarm_active_i;
    end
    else
    begin
      if (alarm_active_i)
        seen <= 1'b1;
      if (step_tick && !steps_full)
        steps <= steps + 8'h01;
    end
  end

  // Below two steps the register shows only the first-assertion mark
  assign timer_value_o = (steps < 8'h02) ? {7'h00, seen} : steps;

endmodule

//--- core/thermal_alarm_pin_control.sv
// Thermal alarm pin control: input timing, fan full_speed_on_alarm, alert and over-temperature output
//
// Operation
// - Alarm timer monitoring runs only while config three bit 1 is set.
// - Config four bits 0 and 1 pick the shared pin function.
// - Full-speed bit drives running fans to full duty while the alarm is asserted.
// - Full-speed bit clear leaves fan duty untouched by the alarm.
// - Mask bit for the used pin suppresses the alert on timer limit exceedance.
// - A zero limit alerts on the very first alarm assertion.
// - Timer accumulates across assertions, saturates, and clears on read.
// - Bit 0 marks first assertion; above 45.52 ms it counts 22.76 ms steps.
// - Timer above limit sets the timer limit flag and alerts unless masked.
// - Enabled channel beyond its critical limit by a quarter degree pulls the pin low while config three bit 1 is set.
// - Pin stays low while above the limit; released at or below it.
// - Once asserted, the pin stays low for a whole monitoring cycle.
// - Three critical limits sit at consecutive offsets for remote one, local, remote two.
// - Config five bits 5 to 7 enable output per channel, any combination.
// - A limit at or below the lowest coded temperature disables that channel.
// - Config seven bit 0 set turns alarm hysteresis off.
// - Alarm-disable bit blocks the pin only while hysteresis is on.
// - Manual fan mode boosts only when config six bit 3 is set.
// - Config four bit 3 picks full duty or programmed maximum duty on full_speed_on_alarm.
// - Config four bit 2 keeps alarm events away from fan duty.
`timescale 1ns/1ns
module thermal_alarm_pin_control
  import thermal_alarm_pkg::*;
#(
  parameter int STEP_CYCLES = TIMER_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register access
  input wire reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Dedicated alarm pin, open drain, active low
  input wire logic thermal_alarm_pin_n_i,
  output logic thermal_alarm_pin_n_o,
  output logic thermal_alarm_pin_oe_o,
  // Shared pin, open drain
  input wire logic shared_pin_i,
  output logic shared_pin_o,
  output logic shared_pin_oe_o,
  output logic fan4_speed_input_o,
  // Temperature monitor
  input wire logic sample_strobe_i,
  input wire logic offset64_mode_i,
  input wire temp_t [NUM_CH-1:0] temp_i,
  // Fan controller
  input wire logic manual_mode_i,
  input wire fan_t [NUM_FANS-1:0] fan_i,
  output logic [NUM_FANS-1:0][7:0] fan_duty_o,
  // Alert
  output logic smbus_alert_n_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] fan_policy_config_six;
  logic [7:0] hysteresis_config_seven;
  logic [7:0] crit_limit [NUM_CH];
  logic [7:0] alert_mask_one;
  logic [7:0] alert_mask_two;
  logic [7:0] general_config_three;
  logic [7:0] output_enable_config_five;
  logic [7:0] pin_and_alarm_config_four;
  logic [7:0] timer_limit;
  logic timer_limit_flag;
  logic [7:0] timer_value;

  // Address match helper, used by both write and read decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Writes are taken in the cycle wr is high
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      fan_policy_config_six <= RST_ZERO;
      hysteresis_config_seven <= RST_ZERO;
      alert_mask_one <= RST_ZERO;
      alert_mask_two <= RST_ZERO;
      general_config_three <= RST_ZERO;
      output_enable_config_five <= RST_ZERO;
      pin_and_alarm_config_four <= RST_ZERO;
      timer_limit <= RST_ZERO;
    end
    else if (reg_req_i.wr)
    begin
      if (hit(reg_req_i.addr, ADDR_FAN_POLICY_SIX))
        fan_policy_config_six <= reg_req_i.wdata;
      if (hit(reg_req_i.addr, ADDR_HYST_SEVEN))
        hysteresis_config_seven <= reg_req_i.wdata;
      if (hit(reg_req_i.addr, ADDR_MASK_ONE))
        alert_mask_one <= reg_req_i.wdata;
      if (hit(reg_req_i.addr, ADDR_MASK_TWO))
        alert_mask_two <= reg_req_i.wdata;
      if (hit(reg_req_i.addr, ADDR_CONFIG_THREE))
        general_config_three <= reg_req_i.wdata;
      if (hit(reg_req_i.addr, ADDR_OUT_ENABLE_FIVE))
        output_enable_config_five <= reg_req_i.wdata;
      if (hit(reg_req_i.addr, ADDR_PIN_CONFIG_FOUR))
        pin_and_alarm_config_four <= reg_req_i.wdata;
      if (hit(reg_req_i.addr, ADDR_TIMER_LIMIT))
        timer_limit <= reg_req_i.wdata;
    end
  end

  // Critical limits at three consecutive offsets
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_crit
      always_ff @(posedge core_clk_i)
      begin
        if (sys_rst_i)
          crit_limit[ch] <= RST_CRIT;
        else if (reg_req_i.wr && hit(reg_req_i.addr, ADDR_R1_CRIT + 8'(ch)))
          crit_limit[ch] <= reg_req_i.wdata;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ded_sync;
  logic [1:0] shr_sync;

  // Both pins are asynchronous, so two flops before any use
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ded_sync <= 2'b11;
      shr_sync <= 2'b11;
    end
    else
    begin
      ded_sync <= {ded_sync[0], thermal_alarm_pin_n_i};
      shr_sync <= {shr_sync[0], shared_pin_i};
    end
  end

  // ----------------------------------------------------------------
  // Pin function and alarm input
  // ----------------------------------------------------------------
  pin_func_t shared_func;
  wire timer_en = general_config_three[CFG3_TIMER_EN];
  wire shared_is_alarm = (shared_func == PIN_ALARM) && timer_en;
  wire alarm_active = timer_en && (!ded_sync[1] || (shared_is_alarm && !shr_sync[1]));

  assign shared_func = pin_func_t'({pin_and_alarm_config_four[CFG4_SEL_B0],
                                    pin_and_alarm_config_four[CFG4_SEL_B1]});

  // Shared pin carries fan speed only in that mode; otherwise held low
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      fan4_speed_input_o <= 1'b0;
    else
      fan4_speed_input_o <= (shared_func == PIN_FAN4_SPEED) && shr_sync[1];
  end

  // ----------------------------------------------------------------
  // Timer, limit flag and alert
  // ----------------------------------------------------------------
  wire timer_read = reg_req_i.rd && hit(reg_req_i.addr, ADDR_TIMER);
  wire status_read = reg_req_i.rd && hit(reg_req_i.addr, ADDR_STATUS_TWO);
  wire limit_exceeded = (timer_value > timer_limit);

  alarm_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .alarm_active_i(alarm_active),
    .clear_i(timer_read),
    .timer_value_o(timer_value)
  );

  // Sticky flag, cleared on status read; a new exceedance wins over the clear
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      timer_limit_flag <= 1'b0;
    else if (limit_exceeded)
      timer_limit_flag <= 1'b1;
    else if (status_read)
      timer_limit_flag <= 1'b0;
  end

  // Mask follows which pin is timing: shared pin uses mask two, else mask one
  wire alert_masked = shared_is_alarm ? alert_mask_two[MASK2_SHARED] : alert_mask_one[MASK1_DEDICATED];
  wire alert_raise = timer_limit_flag && !alert_masked;

  // Registered so the alert pin never glitches
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      smbus_alert_n_o <= 1'b1;
    else
      smbus_alert_n_o <= !alert_raise;
  end

  // ----------------------------------------------------------------
  // Over-temperature output
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] over;
  logic [NUM_CH-1:0] ch_armed;
  logic [NUM_CH-1:0] ch_hot;
  wire hyst_off = hysteresis_config_seven[CFG7_HYST_DIS];
  wire alarm_dis = pin_and_alarm_config_four[CFG4_ALARM_DIS];
  wire out_allowed = !alarm_dis || hyst_off;

  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_over
      // Two's complement codes are flipped so one unsigned compare serves both formats
      wire [7:0] lim_u = offset64_mode_i ? crit_limit[ch] : (crit_limit[ch] ^ SIGN_FLIP);
      wire [7:0] tmp_u = offset64_mode_i ? temp_i[ch].whole : (temp_i[ch].whole ^ SIGN_FLIP);
      wire [9:0] tmp_q = {tmp_u, temp_i[ch].frac};
      wire [9:0] lim_q = {lim_u, FRAC_ZERO};
      wire lim_off = offset64_mode_i ? (crit_limit[ch] <= OFS64_OFF_CODE)
                                     : (crit_limit[ch] == TWOS_OFF_CODE);
      assign ch_armed[ch] = output_enable_config_five[CFG5_EN_LSB + ch] && !lim_off;
      // A quarter degree above the limit is the first code above it
      assign ch_hot[ch] = tmp_q > lim_q;

      // Updated only at the sample strobe, so an assertion lasts a whole cycle
      always_ff @(posedge core_clk_i)
      begin
        if (sys_rst_i)
          over[ch] <= 1'b0;
        else if (sample_strobe_i)
          over[ch] <= ch_armed[ch] && ch_hot[ch];
      end
    end
  endgenerate

  wire drive_low = (|over) && out_allowed;

  // Open drain: only low is ever driven, the pull-up gives the high level
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      thermal_alarm_pin_oe_o <= 1'b0;
      shared_pin_oe_o <= 1'b0;
    end
    else
    begin
      thermal_alarm_pin_oe_o <= drive_low && timer_en;
      shared_pin_oe_o <= (shared_is_alarm && drive_low) || ((shared_func == PIN_ALERT) && alert_raise);
    end
  end
  assign thermal_alarm_pin_n_o = 1'b0;
  assign shared_pin_o = 1'b0;

  // ----------------------------------------------------------------
  // Fan full_speed_on_alarm
  // ----------------------------------------------------------------
  wire full_speed_on_alarm_on = general_config_three[CFG3_FULL_SPEED] && alarm_active
                  && !alarm_dis
                  && (!manual_mode_i || fan_policy_config_six[CFG6_MANUAL_FULL_SPEED_ON_ALARM]);

  generate
    for (ch = 0; ch < NUM_FANS; ch++)
    begin : g_fan
      wire running = (fan_i[ch].duty != DUTY_OFF);
      wire [7:0] full_speed_on_alarm_duty = pin_and_alarm_config_four[CFG4_MAX_DUTY_SEL] ? fan_i[ch].max_duty : DUTY_FULL;
      // Stopped fans are left alone even when full_speed_on_alarm applies
      always_ff @(posedge core_clk_i)
      begin
        if (sys_rst_i)
          fan_duty_o[ch] <= DUTY_OFF;
        else
          fan_duty_o[ch] <= (full_speed_on_alarm_on && running) ? full_speed_on_alarm_duty : fan_i[ch].duty;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = RST_ZERO;
    case (reg_req_i.addr)
      ADDR_FAN_POLICY_SIX: rd_mux = fan_policy_config_six;
      ADDR_HYST_SEVEN: rd_mux = hysteresis_config_seven;
      ADDR_STATUS_TWO: rd_mux = 8'(timer_limit_flag) << STAT2_LIMIT_FLAG;
      ADDR_R1_CRIT: rd_mux = crit_limit[0];
      ADDR_LOCAL_CRIT: rd_mux = crit_limit[1];
      ADDR_R2_CRIT: rd_mux = crit_limit[2];
      ADDR_MASK_ONE: rd_mux = alert_mask_one;
      ADDR_MASK_TWO: rd_mux = alert_mask_two;
      ADDR_CONFIG_THREE: rd_mux = general_config_three;
      ADDR_TIMER: rd_mux = timer_value;
      ADDR_TIMER_LIMIT: rd_mux = timer_limit;
      ADDR_OUT_ENABLE_FIVE: rd_mux = output_enable_config_five;
      ADDR_PIN_CONFIG_FOUR: rd_mux = pin_and_alarm_config_four;
      default: rd_mux = RST_ZERO;
    endcase
  end

  // Read data is captured in the read cycle and held until the next read
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= RST_ZERO;
    else if (reg_req_i.rd)
      reg_rdata_o <= rd_mux;
  end

endmodule

//--- core/thermal_alarm_pkg.sv
// Constants, register map and carrier types for the thermal alarm pin controller
package thermal_alarm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMER_STEP_NS = 22760000;                    // 22.76 ms per timer step
  localparam int TIMER_STEP_CYCLES = TIMER_STEP_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FAN_POLICY_SIX = 8'h10;
  localparam logic [7:0] ADDR_HYST_SEVEN = 8'h11;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
  localparam logic [7:0] ADDR_R1_CRIT = 8'h6A;
  localparam logic [7:0] ADDR_LOCAL_CRIT = 8'h6B;
  localparam logic [7:0] ADDR_R2_CRIT = 8'h6C;
  localparam logic [7:0] ADDR_MASK_ONE = 8'h74;
  localparam logic [7:0] ADDR_MASK_TWO = 8'h75;
  localparam logic [7:0] ADDR_CONFIG_THREE = 8'h78;
  localparam logic [7:0] ADDR_TIMER = 8'h79;
  localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h7A;
  localparam logic [7:0] ADDR_OUT_ENABLE_FIVE = 8'h7C;
  localparam logic [7:0] ADDR_PIN_CONFIG_FOUR = 8'h7D;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG3_TIMER_EN = 1;
  localparam int CFG3_FULL_SPEED = 2;
  localparam int CFG4_SEL_B0 = 0;
  localparam int CFG4_SEL_B1 = 1;
  localparam int CFG4_ALARM_DIS = 2;
  localparam int CFG4_MAX_DUTY_SEL = 3;
  localparam int CFG5_EN_LSB = 5;
  localparam int CFG6_MANUAL_FULL_SPEED_ON_ALARM = 3;
  localparam int CFG7_HYST_DIS = 0;
  localparam int MASK1_DEDICATED = 0;
  localparam int MASK2_SHARED = 5;
  localparam int STAT2_LIMIT_FLAG = 5;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CRIT = 8'h7F;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_OFF = 8'h00;
  localparam logic [7:0] TIMER_FULL = 8'hFF;
  localparam logic [7:0] OFS64_OFF_CODE = 8'h01;            // -63 C in offset-64 coding
  localparam logic [7:0] TWOS_OFF_CODE = 8'h80;             // -128 C in two's complement
  localparam logic [7:0] SIGN_FLIP = 8'h80;
  localparam logic [1:0] FRAC_ZERO = 2'h0;
  localparam int NUM_CH = 3;
  localparam int NUM_FANS = 3;

  // Shared pin function, written {bit0, bit1}
  typedef enum logic [1:0] {
    PIN_FAN4_SPEED = 2'b00,
    PIN_ALARM = 2'b01,
    PIN_ALERT = 2'b10,
    PIN_GPIO = 2'b11
  } pin_func_t;

  // One temperature sample: integer part plus quarter-degree fraction
  typedef struct packed {
    logic [7:0] whole;
    logic [1:0] frac;
  } temp_t;

  // Fan duty from the fan controller
  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] max_duty;
  } fan_t;

  // Register access from the serial bus engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

//--- testbench/thermal_alarm_partner.sv
// Processor hot signal model that pulls the alarm wire low for a commanded span
`timescale 1ns/1ns
module thermal_alarm_partner
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Command from the bench
  input wire logic go_i,
  input wire logic [15:0] len_i,
  // Open-drain pull on the alarm wire
  output logic drive_low_o
);
  logic [15:0] remain;

  // Count the span down; the wire is only ever released, never driven high
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      remain <= 16'h0000;
    else if (go_i)
      remain <= len_i;
    else if (remain != 16'h0000)
      remain <= remain - 16'h0001;
  end
  assign drive_low_o = (remain != 16'h0000);
endmodule

//--- testbench/thermal_alarm_pin_control_properties.sv
// Port-level assertions for the thermal alarm pin controller
`timescale 1ns/1ns
module thermal_alarm_pin_control_properties
  import thermal_alarm_pkg::*;
#(
  parameter int STEP_CYCLES = TIMER_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register access
  input wire reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  // Pins
  input wire logic thermal_alarm_pin_n_i,
  input wire logic thermal_alarm_pin_n_o,
  input wire logic thermal_alarm_pin_oe_o,
  input wire logic shared_pin_i,
  input wire logic shared_pin_o,
  input wire logic shared_pin_oe_o,
  input wire logic fan4_speed_input_o,
  // Temperature monitor
  input wire logic sample_strobe_i,
  input wire logic offset64_mode_i,
  input wire temp_t [NUM_CH-1:0] temp_i,
  // Fans and alert
  input wire logic manual_mode_i,
  input wire fan_t [NUM_FANS-1:0] fan_i,
  input wire logic [NUM_FANS-1:0][7:0] fan_duty_o,
  input wire logic smbus_alert_n_o
);
  // ----------------------------------------------------------------
  // Pin and register checks
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_open_drain: assert property (thermal_alarm_pin_n_o == 1'b0 && shared_pin_o == 1'b0)
    else $error("pin data is not held low");
  a_oe_at_strobe: assert property ($changed(thermal_alarm_pin_oe_o) |-> $past(sample_strobe_i) || $past(sample_strobe_i, 2))
    else $error("alarm pin drive changed away from a strobe");
  a_rdata_hold: assert property (!$past(reg_req_i.rd) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_fan4_sync: assert property (fan4_speed_input_o |-> $past(shared_pin_i, 2) || $past(shared_pin_i, 3))
    else $error("fan speed input high without a high pin");

  // ----------------------------------------------------------------
  // Fan duty checks, one set per fan
  // ----------------------------------------------------------------
  for (genvar k = 0; k < NUM_FANS; k++)
  begin : g_fan
    a_fan_pass: assert property (thermal_alarm_pin_n_i [*6] |-> fan_duty_o[k] == $past(fan_i[k].duty))
      else $error("fan duty altered with no alarm");
    a_no_raise: assert property (fan_duty_o[k] != DUTY_OFF |-> $past(fan_i[k].duty) != DUTY_OFF)
      else $error("stopped fan was started");
    a_full_speed_on_alarm_value: assert property (!$past(sys_rst_i) && fan_duty_o[k] != $past(fan_i[k].duty)
      |-> fan_duty_o[k] == DUTY_FULL || fan_duty_o[k] == $past(fan_i[k].max_duty))
      else $error("boosted duty is neither full nor maximum");
    a_full_speed_on_alarm_cause: assert property (!$past(sys_rst_i) && fan_duty_o[k] != $past(fan_i[k].duty)
      |-> !$past(thermal_alarm_pin_n_i, 2) || !$past(thermal_alarm_pin_n_i, 3)
      || !$past(thermal_alarm_pin_n_i, 4) || !$past(thermal_alarm_pin_n_i, 5))
      else $error("fan boosted without a recent alarm");
  end
endmodule

bind thermal_alarm_pin_control thermal_alarm_pin_control_properties #(.STEP_CYCLES(STEP_CYCLES)) u_props (
  .core_clk_i, .sys_rst_i, .reg_req_i, .reg_rdata_o, .thermal_alarm_pin_n_i, .thermal_alarm_pin_n_o,
  .thermal_alarm_pin_oe_o, .shared_pin_i, .shared_pin_o, .shared_pin_oe_o, .fan4_speed_input_o,
  .sample_strobe_i, .offset64_mode_i, .temp_i, .manual_mode_i, .fan_i, .fan_duty_o, .smbus_alert_n_o);

//--- testbench/thermal_alarm_pin_control_tb.sv
// Self-checking testbench for the thermal alarm pin controller
`timescale 1ns/1ns
module thermal_alarm_pin_control_tb
  import thermal_alarm_pkg::*;
;
  // Short timer step keeps the run brief
  localparam int STEP = 4;
  localparam logic [7:0] AMAP [14] = '{8'h10, 8'h11, 8'h42, 8'h6A, 8'h6B, 8'h6C, 8'h74, 8'h75, 8'h78, 8'h79,
    8'h7A, 8'h7C, 8'h7D, 8'h55};
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  reg_req_t reg_req_i = '0;
  logic [7:0] reg_rdata_o;
  logic pin_n, pin_n_o, pin_oe, sh_wire, sh_o, sh_oe, fan4, hot;
  logic shared_lvl = 1'b1;
  logic sample_strobe_i = 1'b0;
  logic offset64_mode_i = 1'b0;
  logic manual_mode_i = 1'b0;
  temp_t [NUM_CH-1:0] temp_i = '0;
  fan_t [NUM_FANS-1:0] fan_i = {16'h80A0, 16'h4090, 16'h0010};
  logic [NUM_FANS-1:0][7:0] fan_duty_o;
  logic smbus_alert_n_o;
  logic go = 1'b0;
  logic [15:0] len = 16'h0000;
  int miscompares = 0;
  int checks_done = 0;

  // Open-drain wires: low when any party pulls, pull-up otherwise
  assign pin_n = !(pin_oe | hot);
  assign sh_wire = shared_lvl & !sh_oe;

  initial
  begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  thermal_alarm_pin_control #(.STEP_CYCLES(STEP)) DUT (
    .core_clk_i, .sys_rst_i, .reg_req_i, .reg_rdata_o,
    .thermal_alarm_pin_n_i(pin_n), .thermal_alarm_pin_n_o(pin_n_o), .thermal_alarm_pin_oe_o(pin_oe),
    .shared_pin_i(sh_wire), .shared_pin_o(sh_o), .shared_pin_oe_o(sh_oe), .fan4_speed_input_o(fan4),
    .sample_strobe_i, .offset64_mode_i, .temp_i, .manual_mode_i, .fan_i, .fan_duty_o, .smbus_alert_n_o);

  thermal_alarm_partner u_hot (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .len_i(len),
    .drive_low_o(hot));

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // One-cycle request, held until the edge that takes it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_req_i <= {w, !w, a, d};
    @(posedge core_clk_i);
    reg_req_i <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    @(negedge core_clk_i);
    chk(reg_rdata_o, exp);
  endtask

  task automatic hot_for(input int n);
    @(posedge core_clk_i);
    go <= 1'b1;
    len <= 16'(n);
    @(posedge core_clk_i);
    go <= 1'b0;
    cyc(n + 6);
  endtask

  task automatic strb();
    @(posedge core_clk_i);
    sample_strobe_i <= 1'b1;
    @(posedge core_clk_i);
    sample_strobe_i <= 1'b0;
  endtask

  task automatic alert(input logic e);
    @(negedge core_clk_i);
    chk({7'h00, smbus_alert_n_o}, {7'h00, e});
  endtask

  // Fan 0 is stopped, so it must never be raised
  task automatic bst(input logic [7:0] c3, input logic [7:0] c4, input logic [7:0] c6, input logic m,
                     input logic [7:0] e1, input logic [7:0] e2);
    wr(8'h78, c3);
    wr(8'h7D, c4);
    wr(8'h10, c6);
    manual_mode_i <= m;
    @(posedge core_clk_i);
    go <= 1'b1;
    len <= 16'd10;
    @(posedge core_clk_i);
    go <= 1'b0;
    cyc(6);
    @(negedge core_clk_i);
    chk(fan_duty_o[0], 8'h00);
    chk(fan_duty_o[1], e1);
    chk(fan_duty_o[2], e2);
    cyc(12);
  endtask

  // Heat one channel, cool it without a strobe, then strobe the release
  task automatic outc(input logic [7:0] c5, input logic [7:0] c4, input logic [7:0] c7, input logic [7:0] lim,
                      input int ch, input temp_t t, input logic e);
    wr(8'h7C, c5);
    wr(8'h7D, c4);
    wr(8'h11, c7);
    wr(8'h6A + 8'(ch), lim);
    temp_i[ch] <= t;
    strb();
    cyc(2);
    @(negedge core_clk_i);
    chk({7'h00, pin_oe}, {7'h00, e});
    @(posedge core_clk_i);
    temp_i[ch] <= '0;
    cyc(5);
    @(negedge core_clk_i);
    chk({7'h00, pin_oe}, {7'h00, e});
    strb();
    cyc(2);
    @(negedge core_clk_i);
    chk({7'h00, pin_oe}, 8'h00);
  endtask

  // Hang guard, well past the expected run of under two thousand cycles
  initial
  begin
    cyc(20000);
    miscompares++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    cyc(8);
    sys_rst_i <= 1'b0;
    foreach (AMAP[i])
      rd(AMAP[i], (AMAP[i] inside {8'h6A, 8'h6B, 8'h6C}) ? RST_CRIT : RST_ZERO);
    wr(8'h6B, 8'h3C);
    rd(8'h6B, 8'h3C);
    wr(8'h79, 8'h33);
    rd(8'h79, 8'h00);
    // Shared pin in fan speed mode passes its level through
    @(posedge core_clk_i);
    shared_lvl <= 1'b0;
    cyc(5);
    @(negedge core_clk_i);
    chk({7'h00, fan4}, 8'h00);
    @(posedge core_clk_i);
    shared_lvl <= 1'b1;
    cyc(5);
    @(negedge core_clk_i);
    chk({7'h00, fan4}, 8'h01);
    // Cumulative timer with a zero limit
    wr(8'h78, 8'h02);
    rd(8'h79, 8'h00);
    hot_for(20);
    hot_for(22);
    alert(1'b0);
    rd(8'h79, 8'h0A);
    rd(8'h79, 8'h00);
    rd(8'h42, 8'h20);
    rd(8'h42, 8'h00);
    cyc(2);
    alert(1'b1);
    // Masked alert still sets the flag
    wr(8'h74, 8'h01);
    hot_for(8);
    alert(1'b1);
    rd(8'h42, 8'h20);
    rd(8'h79, 8'h02);
    // Flag was re-set by the still-high timer, so only the second status read clears it
    rd(8'h42, 8'h20);
    rd(8'h42, 8'h00);
    wr(8'h74, 8'h00);
    // Nonzero limit: alert only once the timer passes it
    wr(8'h7A, 8'h03);
    hot_for(13);
    alert(1'b1);
    hot_for(4);
    alert(1'b0);
    // Shared pin as alert output pulls low while the alert stands
    wr(8'h7D, 8'h01);
    cyc(2);
    @(negedge core_clk_i);
    chk({7'h00, sh_oe}, 8'h01);
    wr(8'h7D, 8'h00);
    rd(8'h79, 8'h04);
    hot_for(1100);
    rd(8'h79, 8'hFF);
    rd(8'h42, 8'h20);
    wr(8'h78, 8'h00);
    hot_for(20);
    rd(8'h79, 8'h00);
    // Fan policy on alarm
    bst(8'h06, 8'h00, 8'h00, 1'b0, 8'hFF, 8'hFF);
    bst(8'h06, 8'h08, 8'h00, 1'b0, 8'h90, 8'hA0);
    bst(8'h06, 8'h04, 8'h00, 1'b0, 8'h40, 8'h80);
    bst(8'h02, 8'h00, 8'h00, 1'b0, 8'h40, 8'h80);
    bst(8'h06, 8'h00, 8'h00, 1'b1, 8'h40, 8'h80);
    bst(8'h06, 8'h00, 8'h08, 1'b1, 8'hFF, 8'hFF);
    // Over-temperature output
    wr(8'h78, 8'h02);
    outc(8'h20, 8'h00, 8'h00, 8'h50, 0, {8'h50, 2'h1}, 1'b1);
    outc(8'h20, 8'h00, 8'h00, 8'h50, 0, {8'h50, 2'h0}, 1'b0);
    outc(8'h40, 8'h00, 8'h00, 8'h50, 0, {8'h60, 2'h0}, 1'b0);
    outc(8'h80, 8'h00, 8'h00, 8'h80, 2, {8'h05, 2'h0}, 1'b0);
    outc(8'h80, 8'h00, 8'h00, 8'h40, 2, {8'h41, 2'h0}, 1'b1);
    outc(8'hE0, 8'h04, 8'h00, 8'h50, 1, {8'h60, 2'h0}, 1'b0);
    outc(8'hE0, 8'h04, 8'h01, 8'h50, 1, {8'h60, 2'h0}, 1'b1);
    @(posedge core_clk_i);
    offset64_mode_i <= 1'b1;
    outc(8'h20, 8'h00, 8'h00, 8'h01, 0, {8'h40, 2'h0}, 1'b0);
    complete_run();
  end
endmodule
